// File: dbgcp_top.sv
`timescale 1ns/100ps
// Functional notes
// - register transfers: opcode, {0,addr[11:8]}, addr[7:0], size byte
// - register transfers move 1 to 256 bytes; size zero means 256
// - register read returns FFh when not halted or protected
// - memory commands: 16-bit address and size high first; zero means 65536
// - program write discarded unless unlocked, halted and unprotected
// - program read returns FFh when not halted or protected
// - data write stores bytes in order; discarded if not halted or protected
// - data read returns FFh only when not halted; protection ignored
// - crc over program memory high byte first; FFFFh when not halted
// - crc result follows after reading every program byte, one per memory acknowledge
// - step runs one instruction; ignored when not halted or protected
// - stuff runs host opcode plus memory bytes; ignored likewise
// - execute takes whole instruction; blocked case discards one byte
// - 81h resets and stops, 41h resets and runs, 40h resumes
// - control bit 7 halts instruction fetch; clearing restarts processor
// - bit 6 makes break opcode set halt; otherwise it is a no-op
// - under protection writing 0 to halt bit has no effect
// - bit 5 sends FFh to host on each breakpoint halt
// - bit 0 runs device reset sparing debug unit; clears at reset end
// - status: bit 7 halt, bit 6 processor halt, bit 5 protection inactive
// - reserved control 4:1 and status 4:0 read zero
// - register write discarded when not halted; protected allows flash regs only
module dbgcp_top import dbgcp_pkg::*; #(
  parameter int PMEM_BYTES = 65536,
  parameter logic [11:0] FLASH_REG_LO = 12'hFF8,
  parameter logic [11:0] FLASH_REG_HI = 12'hFF9
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_ready_out,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  output dbgcp_mem_req_t mem_req_out,
  input wire logic mem_ack_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic flash_unlocked_in,
  input wire logic read_protect_option_in,
  input wire logic cpu_halt_mode_in,
  input wire logic break_decoded_in,
  input wire logic sys_reset_done_in,
  output logic debug_halt_flag_out,
  output logic sys_reset_req_out,
  output logic step_req_out,
  output logic stuff_req_out,
  output logic exec_req_out,
  output logic [7:0] inst_byte_out,
  output logic [2:0] inst_len_out,
  input wire logic inst_done_in
);
  typedef enum logic [11:0] {
    ST_IDLE = 12'h001, ST_ARG = 12'h002, ST_WDATA = 12'h004, ST_MEMRD = 12'h008,
    ST_SEND = 12'h010, ST_CRC = 12'h020, ST_INST = 12'h040, ST_RUN = 12'h080,
    ST_IBYTE = 12'h100, ST_MEMWR = 12'h200, ST_CTL = 12'h400, ST_SKIP = 12'h800
  } dbgcp_state_t;

  dbgcp_state_t state_q, state_d;
  logic [7:0] cmd_q, cmd_d, ctl_q, ctl_d, tx_q, tx_d;
  logic [2:0] argn_q, argn_d, ilen_q, ilen_d, icnt_q, icnt_d;
  logic [15:0] addr_q, addr_d, cnt_q, cnt_d, crc_res_q, crc_res_d;
  logic [16:0] left_q, left_d;
  logic sendhi_q, sendhi_d, ack_pend_q, ack_pend_d, txv_q, txv_d;
  logic halt_prev_q;
  logic crc_clr, crc_step;
  logic [15:0] crc_val;
  logic [2:0] dec_len;
  logic halted, prot, rx_take, blocked, is_reg;
  dbgcp_mem_req_t req_d;

  assign halted = ctl_q[CTL_HALT_BIT];
  assign prot = read_protect_option_in;
  assign rx_take = rx_valid_in & rx_ready_out;
  assign is_reg = (cmd_q == CMD_WR_REG) | (cmd_q == CMD_RD_REG);

  // block check per command
  function automatic logic cmd_blocked(input logic [7:0] c, input logic h, input logic p,
                                       input logic unl);
    case (c)
      CMD_RD_DMEM, CMD_RD_CRC, CMD_WR_REG: cmd_blocked = !h;
      CMD_WR_PMEM: cmd_blocked = !h | p | !unl;
      default: cmd_blocked = !h | p;
    endcase
  endfunction

  dbgcp_crc16 i_dbgcp_crc16 (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .clear_in(crc_clr),
    .step_in(crc_step), .byte_in(mem_rdata_in), .crc_out(crc_val)
  );
  dbgcp_instlen i_dbgcp_instlen (.opcode_in(rx_data_in), .len_out(dec_len));

  assign blocked = cmd_blocked(cmd_q, halted, prot, flash_unlocked_in);
  // a new command waits until the last reply and any break ack are handed over
  assign rx_ready_out = ((state_q == ST_IDLE) & !txv_q & !ack_pend_q) |
                        (state_q == ST_ARG) | (state_q == ST_WDATA) |
                        (state_q == ST_CTL) | (state_q == ST_IBYTE);
  assign crc_clr = (state_q == ST_IDLE);
  assign crc_step = (state_q == ST_CRC) & mem_ack_in;

  // command sequencer
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    ctl_d = ctl_q;
    tx_d = tx_q;
    txv_d = txv_q;
    argn_d = argn_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    left_d = left_q;
    sendhi_d = sendhi_q;
    crc_res_d = crc_res_q;
    ilen_d = ilen_q;
    icnt_d = icnt_q;
    ack_pend_d = ack_pend_q;
    req_d = '0;
    if (txv_q && tx_ready_in) begin
      txv_d = 1'b0;
    end
    // breakpoint: set halt when enabled, else treated as no-op
    if (break_decoded_in && ctl_q[CTL_BRK_BIT] && !halted) begin
      ctl_d[CTL_HALT_BIT] = 1'b1;
      ack_pend_d = ack_pend_q | ctl_q[CTL_ACK_BIT];
    end
    // self reset bit clears when the system reset completes
    if (sys_reset_done_in) begin
      ctl_d[CTL_RST_BIT] = 1'b0;
    end
    case (state_q)
      ST_IDLE: begin
        if (ack_pend_q && !txv_q) begin
          tx_d = ACK_BYTE;
          txv_d = 1'b1;
          ack_pend_d = 1'b0;
        end else if (rx_take) begin
          cmd_d = rx_data_in;
          argn_d = 3'h0;
          addr_d = '0;
          cnt_d = '0;
          case (rx_data_in)
            CMD_WR_REG, CMD_RD_REG, CMD_WR_PMEM, CMD_RD_PMEM, CMD_WR_DMEM,
            CMD_RD_DMEM: state_d = ST_ARG;
            CMD_WR_CTL, CMD_STUFF, CMD_EXEC: state_d = ST_CTL;
            CMD_RD_CTL, CMD_RD_STAT: begin
              tx_d = (rx_data_in == CMD_RD_CTL) ? (ctl_q & CTL_WMASK) :
                     {halted, cpu_halt_mode_in, !prot, 5'h00};
              sendhi_d = 1'b0;
              state_d = ST_SEND;
            end
            CMD_RD_CRC: begin
              addr_d = '0;
              left_d = 17'(PMEM_BYTES);
              state_d = ST_CRC;
            end
            CMD_STEP: state_d = ST_RUN;
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_CTL: begin
        if (rx_take) begin
          if (cmd_q == CMD_WR_CTL) begin
            ctl_d = (rx_data_in & CTL_WMASK) | (ctl_q & ~CTL_WMASK);
            // protection keeps halt; a break in the same cycle wins over a clear
            if ((prot && halted) || (break_decoded_in && ctl_q[CTL_BRK_BIT])) begin
              ctl_d[CTL_HALT_BIT] = 1'b1;
            end
            state_d = ST_IDLE;
          end else if (blocked) begin
            state_d = ST_IDLE;
          end else begin
            ilen_d = (cmd_q == CMD_EXEC) ? dec_len : 3'h1;
            icnt_d = 3'h1;
            tx_d = rx_data_in;
            state_d = (cmd_q == CMD_EXEC && dec_len != 3'h1) ? ST_IBYTE : ST_RUN;
          end
        end
      end
      ST_IBYTE: begin
        if (rx_take) begin
          icnt_d = icnt_q + 3'h1;
          if (icnt_q + 3'h1 == ilen_q) begin
            state_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (cmd_q == CMD_STEP && blocked) begin
          state_d = ST_IDLE;
        end else if (inst_done_in) begin
          state_d = ST_IDLE;
        end
      end
      ST_ARG: begin
        if (rx_take) begin
          argn_d = argn_q + 3'h1;
          if (argn_q < 3'h2) begin
            addr_d = {addr_q[7:0], rx_data_in};
          end else begin
            cnt_d = {cnt_q[7:0], rx_data_in};
          end
          if ((is_reg && argn_q == 3'h2) || argn_q == 3'h3) begin
            // zero size selects the largest transfer
            if (is_reg) begin
              left_d = (rx_data_in == 8'h00) ? 17'h00100 : {9'h000, rx_data_in};
            end else begin
              left_d = ({cnt_q[7:0], rx_data_in} == 16'h0000) ? 17'h10000 :
                       {1'b0, cnt_q[7:0], rx_data_in};
            end
            state_d = cmd_q[0] ? ST_MEMRD : ST_WDATA;
          end
        end
      end
      ST_WDATA: begin
        if (rx_take) begin
          tx_d = rx_data_in;
          // protected register writes pass only to flash control registers
          if (!blocked && !(cmd_q == CMD_WR_REG && prot && (addr_q[11:0] < FLASH_REG_LO ||
              addr_q[11:0] > FLASH_REG_HI))) begin
            state_d = ST_MEMWR;
          end else begin
            addr_d = addr_q + 16'h0001;
            left_d = left_q - 17'h00001;
            if (left_q == 17'h00001) begin
              state_d = ST_IDLE;
            end
          end
        end
      end
      ST_MEMWR: begin
        req_d = '{valid: 1'b1, write: 1'b1, space: cmd_q[2:1] == 2'h0 ? SPACE_REG :
                  (cmd_q[2] ? SPACE_DMEM : SPACE_PMEM), addr: addr_q, wdata: tx_q};
        if (mem_ack_in) begin
          req_d = '0;
          addr_d = addr_q + 16'h0001;
          left_d = left_q - 17'h00001;
          state_d = (left_q == 17'h00001) ? ST_IDLE : ST_WDATA;
        end
      end
      ST_MEMRD: begin
        if (!txv_q) begin
          if (blocked) begin
            tx_d = BLOCKED_BYTE;
            txv_d = 1'b1;
            state_d = ST_SKIP;
          end else begin
            req_d = '{valid: 1'b1, write: 1'b0, space: cmd_q[2:1] == 2'h0 ? SPACE_REG :
                      (cmd_q[2] ? SPACE_DMEM : SPACE_PMEM), addr: addr_q, wdata: 8'h00};
            if (mem_ack_in) begin
              req_d = '0;
              tx_d = mem_rdata_in;
              txv_d = 1'b1;
              state_d = ST_SKIP;
            end
          end
        end
      end
      ST_SKIP: begin
        // one read byte handed over; advance
        if (!txv_q || tx_ready_in) begin
          addr_d = addr_q + 16'h0001;
          left_d = left_q - 17'h00001;
          state_d = (left_q == 17'h00001) ? ST_IDLE : ST_MEMRD;
        end
      end
      ST_CRC: begin
        if (!halted) begin
          crc_res_d = CRC_BLOCKED;
          state_d = ST_SEND;
          sendhi_d = 1'b1;
        end else begin
          req_d = '{valid: 1'b1, write: 1'b0, space: SPACE_PMEM, addr: addr_q, wdata: 8'h00};
          if (mem_ack_in) begin
            req_d = '0;
            addr_d = addr_q + 16'h0001;
            left_d = left_q - 17'h00001;
            if (left_q == 17'h00001) begin
              crc_res_d = crc_byte_last(crc_val, mem_rdata_in);
              sendhi_d = 1'b1;
              state_d = ST_SEND;
            end
          end
        end
      end
      ST_SEND: begin
        if (!txv_q) begin
          txv_d = 1'b1;
          if (sendhi_q) begin
            tx_d = crc_res_q[15:8];
            sendhi_d = 1'b0;
            state_d = ST_SEND;
            crc_res_d = {crc_res_q[7:0], 8'h00};
            left_d = 17'h00000;
          end else begin
            if (cmd_q == CMD_RD_CRC) begin
              tx_d = crc_res_q[15:8];
            end
            state_d = ST_IDLE;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // fold the last byte of the crc sweep
  function automatic logic [15:0] crc_byte_last(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // sequencer registers
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      cmd_q <= 8'h00;
      ctl_q <= CTL_RESET;
      tx_q <= 8'h00;
      txv_q <= 1'b0;
      argn_q <= 3'h0;
      addr_q <= 16'h0000;
      cnt_q <= 16'h0000;
      left_q <= 17'h00000;
      sendhi_q <= 1'b0;
      crc_res_q <= 16'h0000;
      ilen_q <= 3'h0;
      icnt_q <= 3'h0;
      ack_pend_q <= 1'b0;
      halt_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      ctl_q <= ctl_d;
      tx_q <= tx_d;
      txv_q <= txv_d;
      argn_q <= argn_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      left_q <= left_d;
      sendhi_q <= sendhi_d;
      crc_res_q <= crc_res_d;
      ilen_q <= ilen_d;
      icnt_q <= icnt_d;
      ack_pend_q <= ack_pend_d;
      halt_prev_q <= halted;
    end
  end

  // outputs toward the core and link
  assign mem_req_out = req_d;
  assign tx_valid_out = txv_q;
  assign tx_data_out = tx_q;
  assign debug_halt_flag_out = halted;
  assign sys_reset_req_out = ctl_q[CTL_RST_BIT];
  assign step_req_out = (state_q == ST_RUN) & (cmd_q == CMD_STEP) & !blocked;
  assign stuff_req_out = (state_q == ST_RUN) & (cmd_q == CMD_STUFF);
  assign exec_req_out = (state_q == ST_RUN) & (cmd_q == CMD_EXEC);
  assign inst_byte_out = tx_q;
  assign inst_len_out = ilen_q;

  // protection keeps halt set
  chk_halt_sticky: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (prot && halt_prev_q) |-> halted) else $error("halt cleared under protection");
  // reserved control bits stay zero
  chk_ctl_rsvd: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    ctl_q[4:1] == 4'h0) else $error("reserved control bits set");
  // blocked step never issues
  chk_step_block: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    step_req_out |-> (halted && !prot)) else $error("step while blocked");
  // breakpoint with enable halts next cycle
  chk_brk_halt: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (break_decoded_in && ctl_q[6] && !halted) |=> halted) else $error("break missed");
  // reset bit falls after reset done
  chk_rst_clear: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (sys_reset_done_in && state_q != ST_CTL) |=> !ctl_q[0]) else $error("rst stuck");
  // blocked register read answers FFh
  chk_rd_ff: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (state_q == ST_MEMRD && cmd_q == CMD_RD_REG && !txv_q && blocked) |=>
    (txv_q && tx_q == 8'hFF)) else $error("blocked read not FFh");
  // no memory write when not halted
  chk_wr_halt: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (mem_req_out.valid && mem_req_out.write) |-> halted) else $error("write not halted");
  // tx data holds while waiting
  chk_tx_hold: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (tx_valid_out && !tx_ready_in) |=> (tx_valid_out && $stable(tx_data_out)))
    else $error("tx changed while stalled");
endmodule // dbgcp_top

// File: dbgcp_pkg.sv
package dbgcp_pkg;
  // command opcodes
  localparam logic [7:0] CMD_RD_STAT = 8'h02;
  localparam logic [7:0] CMD_WR_CTL = 8'h04;
  localparam logic [7:0] CMD_RD_CTL = 8'h05;
  localparam logic [7:0] CMD_WR_REG = 8'h08;
  localparam logic [7:0] CMD_RD_REG = 8'h09;
  localparam logic [7:0] CMD_WR_PMEM = 8'h0A;
  localparam logic [7:0] CMD_RD_PMEM = 8'h0B;
  localparam logic [7:0] CMD_WR_DMEM = 8'h0C;
  localparam logic [7:0] CMD_RD_DMEM = 8'h0D;
  localparam logic [7:0] CMD_RD_CRC = 8'h0E;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_STUFF = 8'h11;
  localparam logic [7:0] CMD_EXEC = 8'h12;
  // control and status bit positions
  localparam int CTL_HALT_BIT = 7;
  localparam int CTL_BRK_BIT = 6;
  localparam int CTL_ACK_BIT = 5;
  localparam int CTL_RST_BIT = 0;
  localparam int STAT_DBG_BIT = 7;
  localparam int STAT_CPUHALT_BIT = 6;
  localparam int STAT_PROT_BIT = 5;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WMASK = 8'hE1;
  localparam logic [7:0] BLOCKED_BYTE = 8'hFF;
  localparam logic [7:0] ACK_BYTE = 8'hFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_BLOCKED = 16'hFFFF;
  // memory access request to the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dbgcp_mem_req_t;
  localparam logic [1:0] SPACE_REG = 2'h0;
  localparam logic [1:0] SPACE_PMEM = 2'h1;
  localparam logic [1:0] SPACE_DMEM = 2'h2;
  // byte stream beat
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dbgcp_byte_t;
endpackage

// File: dbgcp_crc16.sv
`timescale 1ns/100ps
// byte-wise crc-ccitt engine
module dbgcp_crc16 import dbgcp_pkg::*; (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic clear_in,
  input wire logic step_in,
  input wire logic [7:0] byte_in,
  output logic [15:0] crc_out
);
  logic [15:0] crc_q, crc_d;

  // one full byte folded per enable
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // next value
  always_comb begin
    crc_d = crc_q;
    if (clear_in) begin
      crc_d = CRC_INIT;
    end else if (step_in) begin
      crc_d = crc_byte(crc_q, byte_in);
    end
  end

  // register
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc_out = crc_q;
endmodule // dbgcp_crc16

// File: dbgcp_instlen.sv
`timescale 1ns/100ps
// instruction length from the first opcode byte
module dbgcp_instlen import dbgcp_pkg::*; (
  input wire logic [7:0] opcode_in,
  output logic [2:0] len_out
);
  // simple length map: low nibble decides, except 88h and 89h which are five bytes long
  always_comb begin
    case (opcode_in[3:0])
      4'hF: len_out = 3'h1;
      4'hC, 4'hD: len_out = (opcode_in[3:0] == 4'hD) ? 3'h3 : 3'h2;
      4'h8, 4'h9: len_out = (opcode_in[7:4] == 4'h8) ? 3'h5 : 3'h3;
      4'h2, 4'h3, 4'hA, 4'hB, 4'hE, 4'h0, 4'h1: len_out = 3'h2;
      4'h4, 4'h5, 4'h6, 4'h7: len_out = 3'h3;
      default: len_out = 3'h4;
    endcase
  end
endmodule // dbgcp_instlen

// File: dbgcp_host_model.sv
`timescale 1ns/100ps
// debug host on the byte link: sends commands, takes replies
module dbgcp_host_model (
  input wire logic core_clk_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_ready_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  int stall = 0; // cycles spent before taking a reply
  // idle link at time zero
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b0;
  end
  // hold a byte until taken; released data shows its inverse
  task automatic send_byte(input logic [7:0] b, output logic ok);
    int n;
    n = 0;
    @(posedge core_clk_in);
    rx_valid_out <= 1'b1;
    rx_data_out <= b;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (rx_ready_in !== 1'b1 && n < 3000);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~b;
    ok = (n < 3000);
  endtask
  // wait out the reply, giving up after 3000 cycles of device computing
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    repeat (stall) @(posedge core_clk_in);
    @(posedge core_clk_in);
    tx_ready_out <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (tx_valid_in !== 1'b1 && n < 3000);
    b = tx_data_in;
    tx_ready_out <= 1'b0;
    ok = (n < 3000);
  endtask
endmodule // dbgcp_host_model

// File: dbgcp_tb_top.sv
`timescale 1ns/100ps
// self-checking bench for the debug command processor
module dbgcp_tb_top import dbgcp_pkg::*;;
  localparam int PM = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, halt, rreq, step, stuff, exec;
  logic mem_ack = 1'b0, unl = 1'b0, prot = 1'b0, chalt = 1'b0, break_opcode = 1'b0;
  logic rdone = 1'b0, idone = 1'b0, rseen = 1'b0, iseen = 1'b0;
  logic [7:0] rx_data, tx_data, ibyte;
  logic [7:0] rdata = 8'h00, ibseen = 8'h00;
  logic [2:0] ilen;
  dbgcp_mem_req_t req;
  logic [25:0] wq[$];
  int n_errors = 0;
  int check_count = 0;
  // system clock
  always #50 clk = ~clk;
  dbgcp_top #(.PMEM_BYTES(PM)) i_dbgcp_top (
    .core_clk_in(clk), .reset_n_in(rst_n), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
    .rx_ready_out(rx_ready), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
    .tx_ready_in(tx_ready), .mem_req_out(req), .mem_ack_in(mem_ack), .mem_rdata_in(rdata),
    .flash_unlocked_in(unl), .read_protect_option_in(prot), .cpu_halt_mode_in(chalt),
    .break_decoded_in(break_opcode), .sys_reset_done_in(rdone), .debug_halt_flag_out(halt),
    .sys_reset_req_out(rreq), .step_req_out(step), .stuff_req_out(stuff),
    .exec_req_out(exec), .inst_byte_out(ibyte), .inst_len_out(ilen), .inst_done_in(idone));
  dbgcp_host_model i_dbgcp_host_model (
    .core_clk_in(clk), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .rx_ready_in(rx_ready), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
    .tx_ready_out(tx_ready));
  // memory contents seen by the block
  function automatic logic [7:0] mv(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  // memory and core answer each request one cycle later
  always @(posedge clk) begin
    mem_ack <= req.valid && !mem_ack;
    rdata <= mv(req.addr);
    if (req.valid && !mem_ack && req.write) begin
      wq.push_back({req.space, req.addr, req.wdata});
    end
    idone <= (step || stuff || exec) && !idone;
    rdone <= rreq && !rdone;
    rseen <= rseen || rreq;
    iseen <= iseen || step || stuff || exec;
    if (stuff || exec) ibseen <= ibyte;
  end
  // verdict and end of run
  task automatic end_of_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) begin
      n_errors++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  // link byte helpers
  task automatic tx(input logic [7:0] b);
    logic ok;
    i_dbgcp_host_model.send_byte(b, ok);
    chk(ok, "byte not taken");
  endtask
  task automatic rx_chk(input logic [7:0] e);
    logic [7:0] b;
    logic ok;
    i_dbgcp_host_model.recv_byte(b, ok);
    chk(ok && (b === e), $sformatf("reply %h expected %h", b, e));
  endtask
  task automatic ctl_wr(input logic [7:0] v);
    tx(CMD_WR_CTL);
    tx(v);
  endtask
  task automatic ctl_rd(input logic [7:0] e);
    tx(CMD_RD_CTL);
    rx_chk(e);
  endtask
  task automatic setin(input logic u, input logic p, input logic h);
    @(posedge clk);
    unl <= u;
    prot <= p;
    chalt <= h;
  endtask
  task automatic pulse_brk();
    @(posedge clk);
    break_opcode <= 1'b1;
    @(posedge clk);
    break_opcode <= 1'b0;
  endtask
  task automatic cmd5(input logic [7:0] op, input logic [15:0] a, input logic [15:0] s);
    tx(op);
    tx(a[15:8]);
    tx(a[7:0]);
    tx(s[15:8]);
    tx(s[7:0]);
  endtask
  // one-byte register read, then one-byte register write
  task automatic reg_case(input logic [11:0] a, input logic [7:0] er, input logic wok,
                          input logic [7:0] ec);
    wq.delete();
    tx(CMD_RD_REG);
    tx({4'h0, a[11:8]});
    tx(a[7:0]);
    tx(8'h01);
    rx_chk(er);
    tx(CMD_WR_REG);
    tx({4'h0, a[11:8]});
    tx(a[7:0]);
    tx(8'h01);
    tx(8'hC3);
    ctl_rd(ec);
    chk(wq.size() == (wok ? 1 : 0), "register write count");
    if (wok) chk(wq[0] === {SPACE_REG, 4'h0, a, 8'hC3}, "register write");
  endtask
  // two-byte memory read, then two-byte write with the paired opcode
  task automatic mem_case(input logic [7:0] rd, input logic [1:0] sp, input logic rok,
                          input logic wok, input logic [7:0] ec);
    wq.delete();
    cmd5(rd, 16'h2345, 16'h0002);
    rx_chk(rok ? mv(16'h2345) : BLOCKED_BYTE);
    rx_chk(rok ? mv(16'h2346) : BLOCKED_BYTE);
    cmd5(rd - 8'h01, 16'h2345, 16'h0002);
    tx(8'hC3);
    tx(8'h3C);
    ctl_rd(ec);
    chk(wq.size() == (wok ? 2 : 0), "memory write count");
    if (wok) chk(wq[0] === {sp, 16'h2345, 8'hC3} && wq[1] === {sp, 16'h2346, 8'h3C}, "order");
  endtask
  // crc request against a locally computed value
  task automatic crc_case(input logic ok);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < PM; i++) begin
      c = c ^ {mv(16'(i)), 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    if (!ok) c = CRC_BLOCKED;
    tx(CMD_RD_CRC);
    rx_chk(c[15:8]);
    rx_chk(c[7:0]);
  endtask
  // instruction command; checks whether the core was asked
  task automatic inst_case(input logic [7:0] op, input logic [7:0] arg, input logic exp,
                           input logic [7:0] ec);
    #1 iseen = 1'b0;
    tx(op);
    if (op != CMD_STEP) tx(arg);
    ctl_rd(ec);
    chk(iseen === exp, "instruction request");
    if (exp && op != CMD_STEP) chk(ibseen === arg && ilen === 3'h1, "first opcode byte");
  endtask
  // status, control, reset, break and protection of the halt bit
  task automatic t_ctl();
    setin(0, 1, 0);
    tx(CMD_RD_STAT);
    rx_chk(8'h00);
    ctl_rd(CTL_RESET);
    setin(0, 0, 1);
    tx(CMD_RD_STAT);
    rx_chk(8'h60);
    ctl_wr(8'h7E);
    ctl_rd(8'h60);
    #1 rseen = 1'b0;
    ctl_wr(8'h81);
    repeat (4) @(posedge clk);
    ctl_rd(8'h80);
    chk(rseen === 1'b1 && halt === 1'b1, "reset and stop");
    tx(CMD_RD_STAT);
    rx_chk(8'hE0);
    ctl_wr(8'h40);
    ctl_rd(8'h40);
    chk(halt === 1'b0, "run");
    #1 rseen = 1'b0;
    ctl_wr(8'h41);
    repeat (4) @(posedge clk);
    ctl_rd(8'h40);
    chk(rseen === 1'b1, "reset and go");
    ctl_wr(8'h60);
    pulse_brk();
    rx_chk(ACK_BYTE);
    ctl_rd(8'hE0);
    ctl_wr(8'h00);
    pulse_brk();
    ctl_rd(8'h00);
    ctl_wr(8'h80);
    setin(0, 1, 1);
    ctl_wr(8'h00);
    ctl_rd(8'h80);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_ctl();
    setin(1, 1, 1);
    reg_case(12'hFF8, BLOCKED_BYTE, 1, 8'h80);
    reg_case(12'h123, BLOCKED_BYTE, 0, 8'h80);
    mem_case(CMD_RD_PMEM, SPACE_PMEM, 0, 0, 8'h80);
    mem_case(CMD_RD_DMEM, SPACE_DMEM, 1, 0, 8'h80);
    crc_case(1);
    inst_case(CMD_STEP, 8'h00, 0, 8'h80);
    inst_case(CMD_EXEC, 8'hAB, 0, 8'h80);
    setin(1, 0, 1);
    reg_case(12'h123, mv(16'h0123), 1, 8'h80);
    tx(CMD_RD_REG);
    tx(8'h01);
    tx(8'h02);
    tx(8'h00);
    for (int i = 0; i < 256; i++) rx_chk(mv(16'h0102 + 16'(i)));
    mem_case(CMD_RD_PMEM, SPACE_PMEM, 1, 1, 8'h80);
    mem_case(CMD_RD_DMEM, SPACE_DMEM, 1, 1, 8'h80);
    setin(0, 0, 1);
    mem_case(CMD_RD_PMEM, SPACE_PMEM, 1, 0, 8'h80);
    i_dbgcp_host_model.stall = 3;
    crc_case(1);
    i_dbgcp_host_model.stall = 0;
    inst_case(CMD_STEP, 8'h00, 1, 8'h80);
    inst_case(CMD_STUFF, 8'h9C, 1, 8'h80);
    inst_case(CMD_EXEC, 8'h8F, 1, 8'h80);
    ctl_wr(8'h00);
    reg_case(12'h123, BLOCKED_BYTE, 0, 8'h00);
    mem_case(CMD_RD_PMEM, SPACE_PMEM, 0, 0, 8'h00);
    mem_case(CMD_RD_DMEM, SPACE_DMEM, 0, 0, 8'h00);
    crc_case(0);
    inst_case(CMD_STEP, 8'h00, 0, 8'h00);
    inst_case(CMD_STUFF, 8'h9C, 0, 8'h00);
    end_of_test();
  end
  // watchdog well past the expected run length
  initial begin
    #4000000;
    n_errors++;
    $display("Error %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule // dbgcp_tb_top
